// *** hdl/irq_pkg.sv ***
// Purpose: shared constants for the interrupt enable and flag logic
// Assumes: 32-bit apb data, registers one aligned word each
// Notes:   offsets are byte addresses
package irq_pkg;
    // register byte offsets
    localparam logic [11:0] ctrl_off      = 12'h000; // interrupt_control
    localparam logic [11:0] peripheral_irq_enable_1_off      = 12'h004; // peripheral_irq_enable_1
    localparam logic [11:0] option_off    = 12'h008; // edge select
    localparam logic [11:0] pflag_off     = 12'h00C; // peripheral flags, read only

    // interrupt_control field positions
    localparam int gie_bit    = 7; // global_irq_enable
    localparam int periph_group_enable_bit   = 6; // periph_group_enable
    localparam int t0ie_bit   = 5; // timer0_ovf_enable
    localparam int ext_pin_irq_enable_bit   = 4; // ext_pin_irq_enable
    localparam int pin_change_enable_bit  = 3; // pin_change_enable
    localparam int t0if_bit   = 2; // timer0_ovf_flag
    localparam int ext_pin_irq_flag_bit   = 1; // ext_pin_irq_flag
    localparam int pin_change_summary_flag_bit  = 0; // pin_change_summary_flag

    // option field position
    localparam int edge_bit   = 6; // ext_edge_select

    // reset values
    localparam logic [7:0] ctrl_rst   = 8'h00;
    localparam logic [7:0] peripheral_irq_enable_1_rst   = 8'h00;
    localparam logic       edge_rst   = 1'h0;

    // vector loaded on interrupt entry
    localparam logic [15:0] irq_vector = 16'h0004;
endpackage : irq_pkg

// *** hdl/interrupt_enable_flag_logic.sv ***
// Purpose: interrupt enables, flags and request to the core, apb register access
// Assumes: all inputs synchronous to pclk; core sends accept and return pulses
// Notes:   one wait state on every apb access
// Operation
// - flags set regardless of any enable
// - global enable passes or blocks all requests
// - group enable gates all peripheral sources
// - timer overflow enable gates its flag
// - external pin enable gates its flag
// - pin change enable gates summary flag
// - timer overflow sets timer flag
// - valid external pin event sets flag
// - summary flag is OR of pin flags
// - summary flag read only, writes ignored
// - control register stored bits reset to zero; summary bit follows pin flags
// - first peripheral enable register, eight enables
// - accept with global enable set clears it, pushes, vectors
// - edge select picks rising or falling
// - return without an accepted entry in the same cycle pops, restores, sets global enable
`timescale 1ns/100ps
module interrupt_enable_flag_logic #(
    parameter int ADDR_W = 12 // apb address width
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              timer0_overflow,
    input  wire logic              ext_pin,
    input  wire logic [7:0]        per_pin_change_flags,
    input  wire logic [7:0]        periph_flags,
    input  wire logic              irq_accept,
    input  wire logic              return_from_irq,
    output logic                   irq_request,
    output logic                   push_pc,
    output logic                   load_vector,
    output logic [15:0]            vector_addr,
    output logic                   pop_return,
    output logic                   restore_context
);

    // whole module state in one record
    typedef struct packed {
        logic        global_irq_enable;       // global_irq_enable
        logic        periph_group_enable;      // periph_group_enable
        logic        t0ie;      // timer0_ovf_enable
        logic        ext_pin_irq_enable;      // ext_pin_irq_enable
        logic        pin_change_enable;     // pin_change_enable
        logic        t0if;      // timer0_ovf_flag
        logic        ext_pin_irq_flag;      // ext_pin_irq_flag
        logic [7:0]  peripheral_irq_enable_1;      // peripheral_irq_enable_1
        logic        edge_sel;  // ext_edge_select
        logic        ext_prev;  // last pin sample
        logic        ext_valid; // prev sample is real
        logic        irq_req;   // request to core
        logic        push;      // push pc pulse
        logic        vload;     // load vector pulse
        logic [15:0] vaddr;     // vector address
        logic        pop;       // pop pulse
        logic        restore;   // restore context pulse
        logic        rdy;       // apb ready
        logic        err;       // apb error
        logic [31:0] rdata;     // apb read data
    } state_t;

    state_t st;      // registered state
    state_t next_st; // next state

    logic       pin_change_summary_flag;     // summary of per-pin flags
    logic       access;    // apb access phase, not yet answered
    logic       done;      // access completes this edge
    logic       wr_en;     // write takes effect this edge
    logic       mapped;    // address hits a register
    logic [7:0] ctrl_view; // control register as read
    logic       ext_rise;  // rising edge seen on pin
    logic       ext_fall;  // falling edge seen on pin
    logic       ext_event; // valid edge for current select
    logic       core_src;  // any enabled core source
    logic       periph_src;// any enabled peripheral source

    // no latch here: the per-pin flags already hold the change events
    // read-only summary, cleared only by clearing every pin flag
    assign pin_change_summary_flag = |per_pin_change_flags;

    // decode and helper terms
    always_comb begin
        access     = psel && penable && !st.rdy;
        done       = psel && penable && st.rdy;
        wr_en      = done && pwrite && pstrb[0] && !st.err;
        // full decode of the low twelve bits; aliases would hide bad offsets
        mapped     = (paddr[11:0] == irq_pkg::ctrl_off) || (paddr[11:0] == irq_pkg::peripheral_irq_enable_1_off)
                  || (paddr[11:0] == irq_pkg::option_off) || (paddr[11:0] == irq_pkg::pflag_off);
        ctrl_view  = {st.global_irq_enable, st.periph_group_enable, st.t0ie, st.ext_pin_irq_enable, st.pin_change_enable, st.t0if, st.ext_pin_irq_flag, pin_change_summary_flag};
        ext_rise   = st.ext_valid && ext_pin && !st.ext_prev;
        ext_fall   = st.ext_valid && !ext_pin && st.ext_prev;
        // either edge arms only after one real sample since reset
        ext_event  = st.edge_sel ? ext_rise : ext_fall;
        core_src   = (st.t0ie && st.t0if)
                  || (st.ext_pin_irq_enable && st.ext_pin_irq_flag)
                  || (st.pin_change_enable && pin_change_summary_flag);
        periph_src = st.periph_group_enable && |(st.peripheral_irq_enable_1 & periph_flags);
    end

    // next-state logic: bus writes first, hardware events override
    always_comb begin
        next_st         = st;
        next_st.push    = 1'b0;
        next_st.vload   = 1'b0;
        next_st.pop     = 1'b0;
        next_st.restore = 1'b0;
        next_st.vaddr   = st.vaddr;

        // apb answer one cycle into the access phase
        // ready comes from a flop, so a held access never sees two answers
        next_st.rdy = access;
        if (access) begin
            next_st.err   = !mapped;
            next_st.rdata = 32'h0000_0000;
            if (!pwrite) begin
                // reads; upper bits read as zero
                case (paddr[11:0])
                    irq_pkg::ctrl_off:   next_st.rdata[7:0] = ctrl_view;
                    irq_pkg::peripheral_irq_enable_1_off:   next_st.rdata[7:0] = st.peripheral_irq_enable_1;
                    irq_pkg::option_off: next_st.rdata[irq_pkg::edge_bit] = st.edge_sel;
                    irq_pkg::pflag_off:  next_st.rdata[7:0] = periph_flags;
                    default:             next_st.rdata = 32'h0000_0000;
                endcase
            end
        end else if (done) begin
            next_st.err = 1'b0;
        end

        // software writes, low byte lane only
        // data taken at the completing edge, never at the first access edge
        if (wr_en) begin
            case (paddr[11:0])
                irq_pkg::ctrl_off: begin
                    next_st.global_irq_enable   = pwdata[irq_pkg::gie_bit];
                    next_st.periph_group_enable  = pwdata[irq_pkg::periph_group_enable_bit];
                    next_st.t0ie  = pwdata[irq_pkg::t0ie_bit];
                    next_st.ext_pin_irq_enable  = pwdata[irq_pkg::ext_pin_irq_enable_bit];
                    next_st.pin_change_enable = pwdata[irq_pkg::pin_change_enable_bit];
                    next_st.t0if  = pwdata[irq_pkg::t0if_bit];
                    next_st.ext_pin_irq_flag  = pwdata[irq_pkg::ext_pin_irq_flag_bit];
                    // summary bit is not stored, write has no effect
                end
                irq_pkg::peripheral_irq_enable_1_off:   next_st.peripheral_irq_enable_1 = pwdata[7:0];
                irq_pkg::option_off: next_st.edge_sel = pwdata[irq_pkg::edge_bit];
                default:             next_st.peripheral_irq_enable_1 = st.peripheral_irq_enable_1;
            endcase
        end

        // flags set by their sources whatever the enables; set beats clear
        if (timer0_overflow) begin
            next_st.t0if = 1'b1;
        end
        if (ext_event) begin
            next_st.ext_pin_irq_flag = 1'b1;
        end

        // pin sampling; first sample after reset is not an edge
        next_st.ext_prev  = ext_pin;
        next_st.ext_valid = 1'b1;

        // core handshake; accept only counts with global enable set
        // an accept with the global enable clear is stale and ignored
        if (irq_accept && st.global_irq_enable) begin
            next_st.global_irq_enable   = 1'b0;
            next_st.push  = 1'b1;
            next_st.vload = 1'b1;
            next_st.vaddr = irq_pkg::irq_vector;
        end else if (return_from_irq) begin
            next_st.global_irq_enable     = 1'b1;
            next_st.pop     = 1'b1;
            next_st.restore = 1'b1;
        end

        // request from current state, one cycle of lag
        // the extra cycle buys a glitch-free request line into the core
        next_st.irq_req = st.global_irq_enable && (core_src || periph_src);
    end

    // state register, everything zero at reset
    // async clear, so the request is low before the first clock arrives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st          <= '0;
            st.global_irq_enable      <= irq_pkg::ctrl_rst[irq_pkg::gie_bit];
            st.periph_group_enable     <= irq_pkg::ctrl_rst[irq_pkg::periph_group_enable_bit];
            st.t0ie     <= irq_pkg::ctrl_rst[irq_pkg::t0ie_bit];
            st.ext_pin_irq_enable     <= irq_pkg::ctrl_rst[irq_pkg::ext_pin_irq_enable_bit];
            st.pin_change_enable    <= irq_pkg::ctrl_rst[irq_pkg::pin_change_enable_bit];
            st.t0if     <= irq_pkg::ctrl_rst[irq_pkg::t0if_bit];
            st.ext_pin_irq_flag     <= irq_pkg::ctrl_rst[irq_pkg::ext_pin_irq_flag_bit];
            st.peripheral_irq_enable_1     <= irq_pkg::peripheral_irq_enable_1_rst;
            st.edge_sel <= irq_pkg::edge_rst;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flops
    assign prdata          = st.rdata;
    assign pready          = st.rdy;
    assign pslverr         = st.err;
    assign irq_request     = st.irq_req;
    assign push_pc         = st.push;
    assign load_vector     = st.vload;
    assign vector_addr     = st.vaddr;
    assign pop_return      = st.pop;
    assign restore_context = st.restore;

    // checks
    // all but the reset check pause while presetn is low
    gie_block_a: assert property (@(posedge pclk) disable iff (!presetn)
        !st.global_irq_enable |=> !irq_request)
        else $error("request raised while global enable clear");

    req_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        irq_request |-> $past(st.global_irq_enable) && ($past(core_src) || $past(periph_src)))
        else $error("request without enabled source");

    periph_block_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!st.periph_group_enable && !core_src) |=> !irq_request)
        else $error("peripheral source passed with group enable clear");

    timer_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        timer0_overflow |=> st.t0if ##0 ctrl_view[irq_pkg::t0if_bit])
        else $error("timer overflow flag not set");

    ext_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.ext_valid && st.edge_sel && ext_pin && !st.ext_prev) |=> st.ext_pin_irq_flag)
        else $error("rising edge did not set pin flag");

    ext_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.ext_valid && !st.edge_sel && !ext_pin && st.ext_prev) |=> st.ext_pin_irq_flag)
        else $error("falling edge did not set pin flag");

    summary_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pwrite && paddr[11:0] == irq_pkg::ctrl_off)
        |=> pready && prdata[irq_pkg::pin_change_summary_flag_bit] == $past(pin_change_summary_flag))
        else $error("summary flag read wrong");

    accept_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
        (irq_accept && st.global_irq_enable) |=> !st.global_irq_enable && push_pc && load_vector
        && vector_addr == irq_pkg::irq_vector ##1 !push_pc && !load_vector)
        else $error("interrupt entry sequence wrong");

    return_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
        (return_from_irq && !(irq_accept && st.global_irq_enable)) |=> st.global_irq_enable && pop_return && restore_context)
        else $error("return sequence wrong");

    apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready ##1 !pready)
        else $error("apb ready not one cycle after access");

    // each gating path is pinned down on its own, so a wrong bit index
    // in the request term shows up as a named failure

    // flag capture must not depend on the source's own enable
    pin_flag_free_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ext_event && !st.ext_pin_irq_enable && !st.global_irq_enable) |=> st.ext_pin_irq_flag)
        else $error("pin flag held back by an enable");

    // each enabled core source reaches the core one cycle later
    timer_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.global_irq_enable && st.t0ie && st.t0if) |=> irq_request)
        else $error("enabled timer flag did not raise request");

    pin_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.global_irq_enable && st.ext_pin_irq_enable && st.ext_pin_irq_flag) |=> irq_request)
        else $error("enabled pin flag did not raise request");

    change_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.global_irq_enable && st.pin_change_enable && pin_change_summary_flag) |=> irq_request)
        else $error("enabled summary flag did not raise request");

    // peripheral path needs the group enable and its own enable
    periph_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.global_irq_enable && st.periph_group_enable && |(st.peripheral_irq_enable_1 & periph_flags)) |=> irq_request)
        else $error("enabled peripheral flag did not raise request");

    // a set timer flag with its enable clear stays off the request
    timer_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!st.t0ie && !(st.ext_pin_irq_enable && st.ext_pin_irq_flag) && !(st.pin_change_enable && pin_change_summary_flag) && !periph_src)
        |=> !irq_request)
        else $error("timer flag passed with its enable clear");

    // summary bit follows the pin flags only; a control write leaves it alone
    summary_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr[11:0] == irq_pkg::ctrl_off) ##1 $stable(per_pin_change_flags)
        |-> pin_change_summary_flag == $past(pin_change_summary_flag))
        else $error("control write changed the summary flag");

    // enable register takes the low byte of an accepted write
    enable_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr[11:0] == irq_pkg::peripheral_irq_enable_1_off) |=> st.peripheral_irq_enable_1 == $past(pwdata[7:0]))
        else $error("enable register write lost");

    // a write without the low byte lane is answered but has no effect
    lane_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
        (done && pwrite && !pstrb[0]) |=> $stable(st.peripheral_irq_enable_1) && $stable(st.edge_sel))
        else $error("write without low lane changed a register");

    // unmapped offsets answer with an error and zero data
    unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !mapped) |=> pready && pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");

    err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("bus error outside an answer");

    // only the low byte carries register bits
    rdata_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && !pwrite) |-> prdata[31:8] == 24'h00_0000)
        else $error("read data above the low byte not zero");

    // entry and exit strobes always travel in pairs
    entry_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
        (push_pc || load_vector) |-> push_pc && load_vector)
        else $error("entry strobes split");

    exit_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pop_return || restore_context) |-> pop_return && restore_context)
        else $error("exit strobes split");

    // vector only moves on an accepted entry
    vaddr_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(irq_accept && st.global_irq_enable) |=> $stable(vector_addr))
        else $error("vector address moved without entry");

    // first cycle after reset never counts as a pin edge
    pin_first_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!st.ext_valid && !wr_en) |=> st.ext_pin_irq_flag == $past(st.ext_pin_irq_flag))
        else $error("false pin edge right after reset");

    // held in reset: stored bits and request read zero; two low samples skip power-up
    reset_clear_a: assert property (@(posedge pclk)
        !presetn ##1 !presetn
        |-> {ctrl_view[7:1], st.peripheral_irq_enable_1, st.edge_sel, irq_request} == 17'h0_0000)
        else $error("state not cleared in reset");

endmodule : interrupt_enable_flag_logic

// *** tb/core_events_model.sv ***
// Purpose: far side of the block: core sequencer pulses and peripheral event sources
// Assumes: every output changes by non-blocking assignment right after a rising pclk edge
// Notes:   level sources change only through the levels task of this model
`timescale 1ns/100ps
module core_events_model (
    input  wire logic       pclk,
    output logic            timer0_overflow,
    output logic            ext_pin,
    output logic [7:0]      per_pin_change_flags,
    output logic [7:0]      periph_flags,
    output logic            irq_accept,
    output logic            return_from_irq
);
    // quiet sources at time zero
    initial begin
        {timer0_overflow, ext_pin, irq_accept, return_from_irq} = 4'h0;
        per_pin_change_flags = 8'h00;
        periph_flags         = 8'h00;
    end
    // one-cycle pulse: 0 overflow, 1 accept, 2 return; ends on the sampling edge
    task pulse(input int sel);
        @(posedge pclk);
        case (sel)
            0: timer0_overflow <= 1'b1;
            1: irq_accept      <= 1'b1;
            default: return_from_irq <= 1'b1;
        endcase
        @(posedge pclk);
        {timer0_overflow, irq_accept, return_from_irq} <= 3'h0;
    endtask : pulse
    // level sources: per-pin change flags and peripheral flags together
    task levels(input logic [7:0] pin_flags, input logic [7:0] periph);
        @(posedge pclk);
        per_pin_change_flags <= pin_flags;
        periph_flags         <= periph;
    endtask : levels
    // pin level change, held two cycles so the edge is seen once
    task pin(input logic v);
        @(posedge pclk);
        ext_pin <= v;
        repeat (2) @(posedge pclk);
    endtask : pin
endmodule : core_events_model

// *** tb/tb_top.sv ***
// Purpose: self-checking bench for the interrupt enable and flag logic
// Assumes: one wait state apb slave, registered request one cycle after state
// Notes:   register tests are sequences of apb calls with expected values
`timescale 1ns/100ps
module tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;   // byte address
    logic [31:0] pwdata = 32'h0, prdata, rd_data;
    logic        pready, pslverr, rd_err, irq_request, push_pc, load_vector;
    logic        pop_return, restore_context, t0, pin, acc, ret;
    logic [7:0]  ppf, pf;           // per-pin and peripheral flags
    logic [3:0]  pstrb = 4'hF;      // byte strobes, low lane gates writes
    logic [15:0] vector_addr;
    int          mismatches = 0, total_checks = 0, cycles = 0;
    always #4 pclk = ~pclk;         // 125 MHz
    core_events_model u_core (.pclk(pclk), .timer0_overflow(t0), .ext_pin(pin),
        .per_pin_change_flags(ppf), .periph_flags(pf), .irq_accept(acc), .return_from_irq(ret));
    interrupt_enable_flag_logic u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer0_overflow(t0),
        .ext_pin(pin), .per_pin_change_flags(ppf), .periph_flags(pf), .irq_accept(acc),
        .return_from_irq(ret), .irq_request(irq_request), .push_pc(push_pc),
        .load_vector(load_vector), .vector_addr(vector_addr), .pop_return(pop_return),
        .restore_context(restore_context));
    // ends the run; the only place with the verdict
    task summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    // hang guard, far beyond the few hundred cycles the tests need
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            summarize();
        end
    end
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // one apb transfer; held until pready is seen high at a rising edge
    task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, 24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_data = prdata;
        rd_err  = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task rdc(input string name, input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk(name, {24'h0, exp}, rd_data);
    endtask : rdc
    // request is registered, so let the state settle first
    task irq_chk(input logic exp);
        repeat (3) @(posedge pclk);
        chk("irq_request", {31'h0, exp}, {31'h0, irq_request});
    endtask : irq_chk
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdc("ctrl reset", 12'h000, 8'h00);
        rdc("peripheral_irq_enable_1 reset", 12'h004, 8'h00);
        apb(1'b1, 12'h004, 8'hA5);
        rdc("peripheral_irq_enable_1", 12'h004, 8'hA5);
        pstrb <= 4'hE;
        apb(1'b1, 12'h004, 8'h00);
        pstrb <= 4'hF;
        rdc("peripheral_irq_enable_1 lane off", 12'h004, 8'hA5);
        $display("test registers done");
        u_core.pulse(0);
        rdc("ctrl t0 flag", 12'h000, 8'h04);
        irq_chk(1'b0);
        apb(1'b1, 12'h000, 8'hA4);
        irq_chk(1'b1);
        u_core.pulse(1);
        #1 chk("accept", 32'h00030004, {push_pc, load_vector, vector_addr});
        rdc("ctrl after accept", 12'h000, 8'h24);
        apb(1'b1, 12'h000, 8'h20);
        u_core.pulse(2);
        #1 chk("return", 32'h3, {pop_return, restore_context});
        rdc("ctrl after return", 12'h000, 8'hA0);
        u_core.pulse(0);
        irq_chk(1'b1);
        apb(1'b1, 12'h000, 8'h24);
        irq_chk(1'b0);
        apb(1'b1, 12'h000, 8'h00);
        $display("test timer and core done");
        u_core.levels(8'h11, 8'h00);
        rdc("summary set", 12'h000, 8'h01);
        apb(1'b1, 12'h000, 8'h00);
        rdc("summary ro", 12'h000, 8'h01);
        apb(1'b1, 12'h000, 8'h88);
        irq_chk(1'b1);
        u_core.levels(8'h01, 8'h00);
        rdc("summary one left", 12'h000, 8'h89);
        u_core.levels(8'h00, 8'h00);
        rdc("summary clear", 12'h000, 8'h88);
        $display("test pin change done");
        u_core.levels(8'h00, 8'h04);
        rdc("pflags", 12'h00C, 8'h04);
        apb(1'b1, 12'h000, 8'h80);
        irq_chk(1'b0);
        apb(1'b1, 12'h000, 8'hC0);
        irq_chk(1'b1);
        u_core.levels(8'h00, 8'h00);
        apb(1'b1, 12'h000, 8'h00);
        $display("test peripheral done");
        u_core.pin(1'b1);
        rdc("rising ignored", 12'h000, 8'h00);
        u_core.pin(1'b0);
        rdc("falling flag", 12'h000, 8'h02);
        apb(1'b1, 12'h000, 8'h92);
        irq_chk(1'b1);
        apb(1'b1, 12'h000, 8'h00);
        apb(1'b1, 12'h008, 8'h40);
        rdc("option", 12'h008, 8'h40);
        u_core.pin(1'b1);
        rdc("rising flag", 12'h000, 8'h02);
        $display("test external pin done");
        apb(1'b1, 12'h000, 8'hFA);
        irq_chk(1'b1);
        @(posedge pclk) presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk("irq after reset", 32'h0, {31'h0, irq_request});
        rdc("ctrl mid reset", 12'h000, 8'h00);
        rdc("peripheral_irq_enable_1 mid reset", 12'h004, 8'h00);
        rdc("option mid reset", 12'h008, 8'h00);
        $display("test mid-run reset done");
        apb(1'b0, 12'h010, 8'h00);
        chk("unmapped err", 32'h1, {31'h0, rd_err});
        chk("unmapped data", 32'h0, rd_data);
        apb(1'b1, 12'h010, 8'hFF);
        chk("unmapped wr err", 32'h1, {31'h0, rd_err});
        $display("test unmapped done");
        summarize();
    end
endmodule : tb_top
